// >>> design/beac_pkg.sv
// Shared constants and types for the byte EEPROM access controller.
`default_nettype none
package beac_pkg;

  // ***************************************************************
  // Geometry and register selects
  // ***************************************************************
  localparam int unsigned MEM_BYTES = 64;
  localparam int unsigned AW        = 6;
  localparam int unsigned DW        = 8;
  localparam logic [1:0]  SEL_ADDR  = 2'h0;
  localparam logic [1:0]  SEL_DATA  = 2'h1;
  localparam logic [1:0]  SEL_CTRL  = 2'h2;

  // ***************************************************************
  // Control field positions, modes and reset values
  // ***************************************************************
  localparam int unsigned CTRL_READ    = 0;
  localparam int unsigned CTRL_PROG    = 1;
  localparam int unsigned CTRL_ARM     = 2;
  localparam int unsigned CTRL_RIE     = 3;
  localparam int unsigned CTRL_MODE_LO = 4;
  localparam int unsigned CTRL_MODE_HI = 5;
  localparam logic [1:0]  MODE_ATOMIC  = 2'h0;
  localparam logic [1:0]  MODE_ERASE   = 2'h1;
  localparam logic [1:0]  MODE_WRITE   = 2'h2;
  localparam logic [1:0]  MODE_RSVD    = 2'h3;
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam logic [2:0]  ARM_CYC     = 3'h4;
  localparam logic [2:0]  READ_STALL  = 3'h4;
  localparam logic [2:0]  PROG_STALL  = 3'h2;
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned TICK_NS     = 1000;
  localparam int unsigned T_ATOMIC_NS = 3_400_000;
  localparam int unsigned T_SPLIT_NS  = 1_800_000;
  localparam int unsigned TICK_DIV    = TICK_NS / CLK_NS;
  localparam int unsigned ATOMIC_TK   = T_ATOMIC_NS / TICK_NS;
  localparam int unsigned SPLIT_TK    = T_SPLIT_NS / TICK_NS;

  // One I/O access from the CPU, all fields sampled on one edge.
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } beac_io_req_t;

endpackage : beac_pkg
`default_nettype wire

// >>> design/beac_prog_timer.sv
// Programming duration timer driven by the oscillator tick divider.
`timescale 1ns/100ps
`default_nettype none
module beac_prog_timer #(
  parameter int unsigned TICK_DIV = beac_pkg::TICK_DIV
) (
  input  wire logic        ref_clk,
  input  wire logic        por_n,
  input  wire logic        start,
  input  wire logic [15:0] ticks,
  output logic             done
);

  logic [15:0] div_reg;
  logic [15:0] left_reg;
  logic        run_reg;
  logic        tick;

  // One-cycle tick every TICK_DIV clocks; restarted so each run is exact.
  assign tick = (div_reg == 16'(TICK_DIV - 1));

  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
      div_reg <= 16'h0000;
    else if (start || tick)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end

  // Remaining ticks; done pulses on the tick that empties it.
  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      left_reg <= 16'h0000;
      run_reg  <= 1'b0;
    end
    else if (start)
    begin
      left_reg <= ticks;
      run_reg  <= 1'b1;
    end
    else if (run_reg && tick)
    begin
      left_reg <= left_reg - 16'h0001;
      if (left_reg == 16'h0001)
        run_reg <= 1'b0;
    end
  end

  assign done = run_reg && tick && (left_reg == 16'h0001);

endmodule : beac_prog_timer
`default_nettype wire

// >>> design/beac_ctrl.sv
// Byte EEPROM access controller: registers, arming, stalls and array.
// What this block does
// - Holds 64 data bytes, linear addresses 0 to 63, each read or written alone.
// - A read strobe stalls the CPU for four clock cycles.
// - A started program strobe stalls the CPU for two clock cycles.
// - Address is six bits; bits 7..6 read zero; reset value is zero.
// - Data register supplies the byte to program and shows the byte read.
// - Control bits 7 and 6 always read zero.
// - Mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Mode writes are ignored while programming is in progress.
// - Reset clears the mode to 00 unless programming is in progress.
// - Ready interrupt enable with global enable requests while the array is ready.
// - The arm bit clears itself four clock cycles after software sets it.
// - Program strobe starts work only while armed, else nothing happens.
// - Program strobe reads one while busy and hardware clears it at the end.
// - Read strobe fetches the addressed byte into the data register at once.
// - While busy, reads are blocked and the address cannot change.
// - While busy, no other operation may start.
// - Write-only programs without erasing; unerased targets end as the AND of old and new byte.
// - Programming time comes from the oscillator tick, not the CPU clock.
// - A reset during programming lets the operation finish.
`timescale 1ns/100ps
`default_nettype none
module beac_ctrl #(
  parameter int unsigned TICK_DIV  = beac_pkg::TICK_DIV,
  parameter int unsigned ATOMIC_TK = beac_pkg::ATOMIC_TK,
  parameter int unsigned SPLIT_TK  = beac_pkg::SPLIT_TK
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  por_n,
  input  wire beac_pkg::beac_io_req_t io_req,
  output logic [7:0]                 io_rdata,
  input  wire logic                  global_irq_en,
  output logic                       cpu_stall,
  output logic                       ready_irq
);

  // ***************************************************************
  // Engine state
  // ***************************************************************
  typedef enum logic [1:0]
  {
    BEAC_IDLE = 2'b01,
    BEAC_PROG = 2'b10
  } beac_state_t;

  beac_state_t eng_reg;
  logic [5:0]  addr_reg;
  logic [7:0]  data_reg;
  logic [1:0]  mode_reg;
  logic        rie_reg;
  logic [2:0]  arm_cnt_reg;
  logic [2:0]  stall_reg;
  logic [1:0]  op_mode_reg;
  logic [5:0]  op_addr_reg;
  logic [7:0]  op_data_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  mem_reg [beac_pkg::MEM_BYTES];
  logic        busy;
  logic        arm;
  logic        wr_addr;
  logic        wr_data;
  logic        wr_ctrl;
  logic        start;
  logic        rd_go;
  logic        done;
  logic [15:0] op_ticks;

  // Select decode shared by every write path.
  function automatic logic hit(input beac_pkg::beac_io_req_t r,
                               input logic [1:0] s);
    hit = r.wr && (r.sel == s);
  endfunction : hit

  // Duration in oscillator ticks for a mode.
  function automatic logic [15:0] mode_ticks(input logic [1:0] m);
    mode_ticks = (m == beac_pkg::MODE_ATOMIC) ? 16'(ATOMIC_TK)
                                              : 16'(SPLIT_TK);
  endfunction : mode_ticks

  assign busy    = (eng_reg == BEAC_PROG);
  assign arm     = (arm_cnt_reg != 3'h0);
  assign wr_addr = hit(io_req, beac_pkg::SEL_ADDR);
  assign wr_data = hit(io_req, beac_pkg::SEL_DATA);
  assign wr_ctrl = hit(io_req, beac_pkg::SEL_CTRL);

  // Start needs the arm window, an idle engine and a defined mode.
  assign start = wr_ctrl && io_req.wdata[beac_pkg::CTRL_PROG]
                 && arm && !busy
                 && (mode_reg != beac_pkg::MODE_RSVD);
  // A read shares no cycle with a start and never runs while busy.
  assign rd_go = wr_ctrl && io_req.wdata[beac_pkg::CTRL_READ]
                 && !busy && !start;
  assign op_ticks = mode_ticks(mode_reg);

  // ***************************************************************
  // CPU-side registers
  // ***************************************************************

  // Address: six bits, frozen while programming.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      addr_reg <= 6'h00;
    else if (wr_addr && !busy)
      addr_reg <= io_req.wdata[5:0];
  end

  // Data: loaded by software or by a read strobe.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      data_reg <= 8'h00;
    else if (rd_go)
      data_reg <= mem_reg[addr_reg];
    else if (wr_data)
      data_reg <= io_req.wdata;
  end

  // Mode survives a reset that lands during programming.
  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
      mode_reg <= beac_pkg::MODE_RST;
    else if (!nrst && !busy)
      mode_reg <= beac_pkg::MODE_RST;
    else if (nrst && wr_ctrl && !busy)
      mode_reg <= io_req.wdata[beac_pkg::CTRL_MODE_HI:beac_pkg::CTRL_MODE_LO];
  end

  // Ready interrupt enable.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rie_reg <= 1'b0;
    else if (wr_ctrl)
      rie_reg <= io_req.wdata[beac_pkg::CTRL_RIE];
  end

  // Arm window: high for exactly four cycles after software sets it.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      arm_cnt_reg <= 3'h0;
    else if (wr_ctrl && io_req.wdata[beac_pkg::CTRL_ARM])
      arm_cnt_reg <= beac_pkg::ARM_CYC;
    else if (arm)
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
  end

  // CPU halt counter; a read halts longer than a program start.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      stall_reg <= 3'h0;
    else if (rd_go)
      stall_reg <= beac_pkg::READ_STALL;
    else if (start)
      stall_reg <= beac_pkg::PROG_STALL;
    else if (stall_reg != 3'h0)
      stall_reg <= stall_reg - 3'h1;
  end

  // Read data is registered, so it appears one cycle after rd.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= 8'h00;
    else if (io_req.rd)
    begin
      unique case (io_req.sel)
        beac_pkg::SEL_ADDR: rdata_reg <= {2'b00, addr_reg};
        beac_pkg::SEL_DATA: rdata_reg <= data_reg;
        beac_pkg::SEL_CTRL: rdata_reg <= {2'b00, mode_reg, rie_reg,
                                          arm, busy, 1'b0};
        default:            rdata_reg <= 8'h00;
      endcase
    end
  end

  assign io_rdata  = rdata_reg;
  assign cpu_stall = (stall_reg != 3'h0);
  // Level request, so software must drop the enable to silence it.
  assign ready_irq = rie_reg && !busy && global_irq_en;

  // ***************************************************************
  // Programming engine, kept alive across system reset
  // ***************************************************************

  // Only power-on reset stops the engine, so a started byte completes.
  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
      eng_reg <= BEAC_IDLE;
    else
    begin
      unique case (eng_reg)
        BEAC_IDLE: if (start) eng_reg <= BEAC_PROG;
        BEAC_PROG: if (done) eng_reg <= BEAC_IDLE;
        default:   eng_reg <= BEAC_IDLE;
      endcase
    end
  end

  // Operands are latched so later register writes cannot disturb them.
  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      op_mode_reg <= beac_pkg::MODE_RST;
      op_addr_reg <= 6'h00;
      op_data_reg <= 8'h00;
    end
    else if (start)
    begin
      op_mode_reg <= mode_reg;
      op_addr_reg <= addr_reg;
      op_data_reg <= data_reg;
    end
  end

  // Duration counted in oscillator ticks rather than CPU cycles.
  beac_prog_timer #(
    .TICK_DIV (TICK_DIV)
  ) u_timer (
    .ref_clk (ref_clk),
    .por_n   (por_n),
    .start   (start),
    .ticks   (op_ticks),
    .done    (done)
  );

  // ***************************************************************
  // Array: nonvolatile, so it has no reset
  // ***************************************************************
  // Write-only ANDs into the old cell, as real cells only lose charge.
  for (genvar i = 0; i < beac_pkg::MEM_BYTES; i++)
  begin : g_cell
    always_ff @(posedge ref_clk)
    begin
      if (done && (op_addr_reg == 6'(i)))
      begin
        unique case (op_mode_reg)
          beac_pkg::MODE_ATOMIC: mem_reg[i] <= op_data_reg;
          beac_pkg::MODE_ERASE:  mem_reg[i] <= beac_pkg::ERASED_BYTE;
          beac_pkg::MODE_WRITE:  mem_reg[i] <= mem_reg[i] & op_data_reg;
          default:               mem_reg[i] <= mem_reg[i];
        endcase
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_read_stall;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    rd_go |=> cpu_stall [*4] ##1 !cpu_stall;
  endproperty
  a_read_stall: assert property (p_read_stall)
    else $error("read stall is not four cycles");

  property p_prog_stall;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    start |=> cpu_stall [*2] ##1 !cpu_stall;
  endproperty
  a_prog_stall: assert property (p_prog_stall)
    else $error("program stall is not two cycles");

  property p_arm_window;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    (wr_ctrl && io_req.wdata[beac_pkg::CTRL_ARM]) ##1
      (!wr_ctrl || !io_req.wdata[beac_pkg::CTRL_ARM]) [*4] |=> !arm;
  endproperty
  a_arm_window: assert property (p_arm_window)
    else $error("arm bit not cleared after four cycles");

  property p_no_arm_no_start;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    (wr_ctrl && io_req.wdata[beac_pkg::CTRL_PROG] && !arm && !busy) |=> !busy;
  endproperty
  a_no_arm_no_start: assert property (p_no_arm_no_start)
    else $error("program started without arm");

  property p_mode_frozen;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    (busy && wr_ctrl) |=> $stable(mode_reg);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("mode changed while busy");

  property p_addr_frozen;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    busy |-> !rd_go ##1 $stable(addr_reg);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen)
    else $error("address or read moved while busy");

  property p_busy_ends_on_done;
    @(posedge ref_clk) disable iff (!por_n)
    $fell(busy) |-> $past(done);
  endproperty
  a_busy_ends_on_done: assert property (p_busy_ends_on_done)
    else $error("busy cleared before time elapsed");

  property p_irq_quiet_busy;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    busy |-> !ready_irq;
  endproperty
  a_irq_quiet_busy: assert property (p_irq_quiet_busy)
    else $error("ready request while busy");

  property p_irq_ready;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    (rie_reg && global_irq_en && !busy) |-> ready_irq;
  endproperty
  a_irq_ready: assert property (p_irq_ready)
    else $error("ready request missing");

  property p_mode_reset;
    @(posedge ref_clk) disable iff (!por_n)
    (!nrst && !busy) |=> (mode_reg == beac_pkg::MODE_RST);
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("mode not cleared by reset");

  // A system reset during programming must leave the running mode alone.
  property p_mode_kept_busy;
    @(posedge ref_clk) disable iff (!por_n)
    (!nrst && busy) |=> $stable(mode_reg);
  endproperty
  a_mode_kept_busy: assert property (p_mode_kept_busy)
    else $error("mode cleared by reset while busy");

  property p_addr_high_zero;
    @(posedge ref_clk) disable iff (!nrst || !por_n)
    (io_req.rd && io_req.sel == beac_pkg::SEL_ADDR) |=> (io_rdata[7:6] == 2'b00);
  endproperty
  a_addr_high_zero: assert property (p_addr_high_zero)
    else $error("address reserved bits not zero");

endmodule : beac_ctrl
`default_nettype wire

// >>> test/beac_ctrl_tb_top.sv
// Self-checking testbench for the byte EEPROM access controller.
`timescale 1ns/100ps
`default_nettype none
module beac_ctrl_tb_top;
  // ***************************************************************
  // Shortened timing, stimulus and observed signals
  // ***************************************************************
  // A small tick divider keeps each programming run to at most two dozen cycles.
  localparam int unsigned TD   = 4;
  localparam int unsigned T_AT = 6 * TD;
  localparam int unsigned T_SP = 3 * TD;
  localparam logic [1:0]  S_AD = beac_pkg::SEL_ADDR;
  localparam logic [1:0]  S_DT = beac_pkg::SEL_DATA;
  localparam logic [1:0]  S_CT = beac_pkg::SEL_CTRL;
  logic                   ref_clk       = 1'b0;
  logic                   nrst          = 1'b0;
  logic                   por_n         = 1'b0;
  logic                   global_irq_en = 1'b1;
  beac_pkg::beac_io_req_t io_req        = '0;
  logic [7:0]             io_rdata;
  logic                   cpu_stall;
  logic                   ready_irq;
  logic [7:0]             rd_val;
  int                     cyc           = 0;
  int                     t0            = 0;
  int                     mismatches    = 0;
  int                     check_count   = 0;

  beac_ctrl #(.TICK_DIV(TD), .ATOMIC_TK(6), .SPLIT_TK(3)) beac_ctrl_i
  (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .por_n        (por_n),
    .io_req       (io_req),
    .io_rdata     (io_rdata),
    .global_irq_en(global_irq_en),
    .cpu_stall    (cpu_stall),
    .ready_irq    (ready_irq)
  );

  // Free-running clock and a cycle count used to time busy periods.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ***************************************************************
  // Access tasks
  // ***************************************************************
  // Compare one byte and report at once on a difference.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One register write, held for exactly one taking edge.
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    io_req <= {1'b1, 1'b0, s, d};
    @(posedge ref_clk);
    io_req <= '0;
  endtask : wr

  // One register read; the answer holds, so it is taken a cycle late.
  task automatic rd(input logic [1:0] s);
    @(posedge ref_clk);
    io_req <= {1'b0, 1'b1, s, 8'h00};
    @(posedge ref_clk);
    io_req <= '0;
    @(posedge ref_clk);
    #1;
    rd_val = io_rdata;
  endtask : rd

  // Stall must stand n cycles after the taking edge, then drop.
  task automatic stall(input int n);
    for (int i = 0; i <= n; i++)
    begin
      #1;
      chk({7'h0, cpu_stall}, {7'h0, i < n});
      @(posedge ref_clk);
    end
  endtask : stall

  // Arm, optionally idle, then strobe; the cycle count marks the start.
  task automatic start(input logic [1:0] m, input int gap);
    wr(S_CT, {2'b00, m, 4'hc});
    repeat (gap) @(posedge ref_clk);
    wr(S_CT, {2'b00, m, 4'ha});
    #1;
    t0 = cyc;
  endtask : start

  // Busy must last t cycles, the programmed ticks times the divider, with one cycle of slack.
  task automatic wait_ready(input int t);
    #1;
    while (ready_irq !== 1'b1 && cyc < t0 + 2000)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk({7'h0, cyc - t0 >= t && cyc - t0 <= t + 1}, 8'h01);
  endtask : wait_ready

  task automatic prog(input logic [1:0] m, input int t);
    start(m, 0);
    stall(2);
    wait_ready(t);
  endtask : prog

  // A refused strobe leaves the ready request standing.
  task automatic no_start(input logic [1:0] m, input int gap);
    start(m, gap);
    repeat (3)
    begin
      chk({7'h0, ready_irq}, 8'h01);
      @(posedge ref_clk);
      #1;
    end
  endtask : no_start

  // Read strobe with ready enable kept on, then fetch the data register.
  task automatic get(input logic [7:0] a);
    wr(S_AD, a);
    wr(S_CT, 8'h09);
    stall(4);
    rd(S_DT);
  endtask : get

  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // ***************************************************************
  // Test sequence and watchdog
  // ***************************************************************
  initial
  begin
    repeat (4) @(posedge ref_clk);
    nrst  <= 1'b1;
    por_n <= 1'b1;
    rd(S_CT);
    chk(rd_val, 8'h00);
    wr(S_AD, 8'hff);
    rd(S_AD);
    chk(rd_val, 8'h3f);
    wr(S_CT, 8'hc8);
    rd(S_CT);
    chk(rd_val, 8'h08);
    rd(2'h3);
    chk(rd_val, 8'h00);
    wr(S_CT, 8'h0c);
    rd(S_CT);
    chk(rd_val, 8'h0c);
    rd(S_CT);
    chk(rd_val, 8'h08);
    // Both ends of the space, atomic mode, then read back.
    wr(S_AD, 8'h3f);
    wr(S_DT, 8'h5a);
    rd(S_DT);
    chk(rd_val, 8'h5a);
    prog(beac_pkg::MODE_ATOMIC, T_AT);
    wr(S_AD, 8'h00);
    wr(S_DT, 8'hc3);
    prog(beac_pkg::MODE_ATOMIC, T_AT);
    get(8'h3f);
    chk(rd_val, 8'h5a);
    get(8'h00);
    chk(rd_val, 8'hc3);
    // Split erase, write onto erased, then write onto unerased.
    wr(S_AD, 8'h3f);
    prog(beac_pkg::MODE_ERASE, T_SP);
    get(8'h3f);
    chk(rd_val, 8'hff);
    wr(S_DT, 8'h3c);
    prog(beac_pkg::MODE_WRITE, T_SP);
    get(8'h3f);
    chk(rd_val, 8'h3c);
    wr(S_DT, 8'h0f);
    prog(beac_pkg::MODE_WRITE, T_SP);
    get(8'h3f);
    chk(rd_val, 8'h0c);
    // Reserved mode, expired arm, unarmed strobe, then the last valid gap.
    wr(S_DT, 8'h99);
    no_start(beac_pkg::MODE_RSVD, 0);
    no_start(beac_pkg::MODE_ATOMIC, 3);
    wr(S_CT, 8'h0a);
    #1;
    chk({7'h0, ready_irq}, 8'h01);
    get(8'h3f);
    chk(rd_val, 8'h0c);
    // The read strobe above reloaded the data register, so load the byte again.
    wr(S_DT, 8'h99);
    start(beac_pkg::MODE_ATOMIC, 2);
    wait_ready(T_AT);
    get(8'h3f);
    chk(rd_val, 8'h99);
    // Address, mode, read strobe and program strobe writes made while busy are refused.
    wr(S_AD, 8'h14);
    wr(S_DT, 8'h44);
    start(beac_pkg::MODE_ATOMIC, 0);
    wr(S_AD, 8'h15);
    wr(S_CT, 8'h29);
    stall(0);
    rd(S_AD);
    chk(rd_val, 8'h14);
    rd(S_CT);
    chk(rd_val, 8'h0a);
    rd(S_DT);
    chk(rd_val, 8'h44);
    wr(S_CT, 8'h0c);
    wr(S_CT, 8'h0a);
    wait_ready(T_AT);
    get(8'h14);
    chk(rd_val, 8'h44);
    // System reset in mid-erase: mode kept, erase still lands.
    wr(S_AD, 8'h1e);
    start(beac_pkg::MODE_ERASE, 0);
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd_val = 8'h02;
    for (int i = 0; i < 40 && rd_val[1] !== 1'b0; i++) rd(S_CT);
    chk(rd_val, 8'h10);
    get(8'h1e);
    chk(rd_val, 8'hff);
    get(8'h00);
    chk(rd_val, 8'hc3);
    wr(S_CT, 8'h18);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(S_CT);
    chk(rd_val, 8'h00);
    // Ready request gating by both enables.
    wr(S_CT, 8'h08);
    #1;
    chk({7'h0, ready_irq}, 8'h01);
    @(posedge ref_clk);
    global_irq_en <= 1'b0;
    #1;
    chk({7'h0, ready_irq}, 8'h00);
    @(posedge ref_clk);
    global_irq_en <= 1'b1;
    #1;
    chk({7'h0, ready_irq}, 8'h01);
    wr(S_CT, 8'h00);
    #1;
    chk({7'h0, ready_irq}, 8'h00);
    end_of_test();
  end

  // A hang counts as a failure; the full run needs well under 3000 cycles.
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : beac_ctrl_tb_top
`default_nettype wire
